// File: pkg/hcir_pkg.sv
// Package for the hub configuration and identifier register slice
// ****************************************************************
// Function
// - Language code low register is the low byte of the index 0 language code.
// - Index 0 string descriptor carries exactly one language code, never more.
// - Language code low register resets to 09h, giving 0409h with the high byte.
// - Language code low is writable only while string override enable is 1.
// ****************************************************************
package hcir_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] HCIR_OFF_POLARITY = 8'h0B;
    localparam logic [7:0] HCIR_OFF_UID_FIRST = 8'h10;
    localparam logic [7:0] HCIR_OFF_UID_LAST = 8'h1F;
    localparam logic [7:0] HCIR_OFF_LANG_LOW = 8'h20;

    // ****************************************************************
    // Field layout and reset values
    // ****************************************************************
    localparam int HCIR_NUM_PORTS = 5;
    localparam int HCIR_POL_FLAG_BIT = 7;
    localparam int HCIR_POL_SWAP_MSB = 4;
    localparam int HCIR_UID_BYTES = 16;
    localparam logic [7:0] HCIR_RST_POLARITY = 8'h00;
    localparam logic [7:0] HCIR_RST_LANG_LOW = 8'h09;
    localparam logic [7:0] HCIR_READ_NONE = 8'h00;

    // ****************************************************************
    // Language table string descriptor
    // ****************************************************************
    localparam logic [7:0] HCIR_LANG_DESC_INDEX = 8'h00;
    localparam logic [7:0] HCIR_DESC_LENGTH = 8'h04;
    localparam logic [7:0] HCIR_DESC_TYPE_STRING = 8'h03;
    localparam logic [1:0] HCIR_DESC_LAST_POS = 2'h3;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } hcir_cfg_req_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic rvalid;
        logic wr_ignored;
    } hcir_cfg_rsp_t;

    typedef struct packed {
        logic [7:0] data;
        logic valid;
        logic last;
    } hcir_desc_byte_t;

    typedef enum logic [0:0] {
        HCIR_DESC_IDLE = 1'b0,
        HCIR_DESC_SEND = 1'b1
    } hcir_desc_state_t;

endpackage

// File: tb/hcir_config_regs_asserts.sv
// Concurrent checks on the configuration register slice ports
`timescale 1ns/100ps
`default_nettype none
module hcir_config_regs_asserts #(
    parameter int NUM_PORTS = 5
) (
    input wire logic mclk,
    input wire logic rst,
    input wire hcir_pkg::hcir_cfg_req_t cfg_req,
    input wire hcir_pkg::hcir_cfg_rsp_t cfg_rsp,
    input wire logic string_override_enable,
    input wire logic [NUM_PORTS-1:0] otp_pair_swap,
    input wire logic [NUM_PORTS-1:0] port_pair_swap,
    input wire logic polarity_override_enable,
    input wire logic [7:0] lang_code_low,
    input wire logic [7:0] lang_code_high,
    input wire logic [NUM_PORTS-1:0] line_dp,
    input wire logic [NUM_PORTS-1:0] line_dm,
    input wire logic [NUM_PORTS-1:0] core_dp,
    input wire logic desc_req,
    input wire logic [7:0] desc_index,
    input wire hcir_pkg::hcir_desc_byte_t desc_byte,
    input wire logic desc_busy,
    input wire logic desc_unsupported
);
    import hcir_pkg::*;
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire lang_wr = cfg_req.wr && cfg_req.addr == HCIR_OFF_LANG_LOW;
    wire desc_go = desc_req && !desc_busy;
    property p_desc;
        logic [7:0] lo, hi;
        (desc_go && desc_index == HCIR_LANG_DESC_INDEX, lo = lang_code_low, hi = lang_code_high)
        |-> ##2 (desc_byte.valid && desc_byte.data == HCIR_DESC_LENGTH)
        ##1 (desc_byte.data == HCIR_DESC_TYPE_STRING && !desc_byte.last)
        ##1 (desc_byte.data == lo) ##1 (desc_byte.valid && desc_byte.last && desc_byte.data == hi)
        ##1 !desc_byte.valid;
    endproperty
    a_lang_reset: assert property (disable iff (1'b0) rst |=> lang_code_low == HCIR_RST_LANG_LOW)
        else $error("lang low not at reset value");
    a_lang_locked: assert property (lang_wr && !string_override_enable |=> $stable(lang_code_low) && cfg_rsp.wr_ignored)
        else $error("locked lang low changed");
    a_lang_write: assert property (lang_wr && string_override_enable |=> lang_code_low == $past(cfg_req.wdata))
        else $error("lang low write lost");
    a_swap_otp: assert property (!polarity_override_enable |-> port_pair_swap == otp_pair_swap)
        else $error("swap bits differ from defaults");
    a_swap_lines: assert property (!$past(rst) |-> core_dp == (($past(port_pair_swap) & $past(line_dm))
        | (~$past(port_pair_swap) & $past(line_dp))))
        else $error("pair swap wrong");
    a_desc_bytes: assert property (p_desc)
        else $error("descriptor bytes wrong");
    a_desc_other: assert property (desc_go && desc_index != HCIR_LANG_DESC_INDEX |=> desc_unsupported && !desc_busy)
        else $error("unsupported index not flagged");
    cover property (desc_byte.last);
    cover property (cfg_rsp.wr_ignored);
    cover property (polarity_override_enable && |port_pair_swap);
endmodule
bind hcir_config_regs hcir_config_regs_asserts #(.NUM_PORTS(NUM_PORTS)) chk_i (.mclk, .rst, .cfg_req, .cfg_rsp,
    .string_override_enable, .otp_pair_swap, .port_pair_swap, .polarity_override_enable, .lang_code_low,
    .lang_code_high, .line_dp, .line_dm, .core_dp, .desc_req, .desc_index, .desc_byte, .desc_busy, .desc_unsupported);
`default_nettype wire

// File: tb/hcir_config_regs_test.sv
// Self-checking bench for the configuration register slice
`timescale 1ns/100ps
`default_nettype none
module hcir_config_regs_test;
    import hcir_pkg::*;
    // ****************************************************************
    // Stimulus and checks
    // ****************************************************************
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic string_override_enable = 1'b0;
    logic desc_req = 1'b0;
    logic [4:0] otp_pair_swap = 5'h15;
    logic [4:0] line_dp = 5'h1F;
    logic [4:0] line_dm = 5'h00;
    logic [4:0] port_pair_swap, core_dp, core_dm;
    logic [127:0] unique_id = 128'hFFEEDDCCBBAA99887766554433221100;
    logic [7:0] lang_code_high = 8'h04;
    logic [7:0] desc_index = 8'h00;
    logic [7:0] lang_code_low, d;
    logic polarity_override_enable, desc_busy, desc_unsupported;
    hcir_cfg_req_t cfg_req;
    hcir_cfg_rsp_t cfg_rsp;
    hcir_desc_byte_t desc_byte;
    int num_errors = 0;
    int tests_run = 0;
    always #10 mclk = ~mclk;
    hcir_host host (.mclk, .cfg_req, .cfg_rsp);
    hcir_config_regs uut (.mclk, .rst, .cfg_req, .cfg_rsp, .string_override_enable, .otp_pair_swap, .unique_id,
        .lang_code_high, .port_pair_swap, .polarity_override_enable, .lang_code_low, .line_dp, .line_dm,
        .core_dp, .core_dm, .desc_req, .desc_index, .desc_byte, .desc_busy, .desc_unsupported);
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic close_out;
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic t_reset;
        host.rd(8'h20, d);
        chk(d, 8'h09);
        host.rd(8'h0B, d);
        chk(d, 8'h15);
    endtask
    task automatic t_lang;
        host.wr(8'h20, 8'h5A);
        chk({7'h00, cfg_rsp.wr_ignored}, 8'h01);
        host.rd(8'h20, d);
        chk(d, 8'h09);
        string_override_enable = 1'b1;
        host.wr(8'h20, 8'h5A);
        host.rd(8'h20, d);
        chk(d, 8'h5A);
        chk(lang_code_low, 8'h5A);
    endtask
    task automatic t_desc;
        logic [7:0] e [4];
        e = '{8'h04, 8'h03, 8'h5A, 8'h04};
        @(negedge mclk);
        desc_req = 1'b1;
        @(negedge mclk);
        desc_req = 1'b0;
        desc_index = 8'h03;
        chk({7'h00, desc_busy}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk);
            chk(desc_byte.data, e[i]);
            chk({6'h00, desc_byte.valid, desc_byte.last}, {7'h01, i == 3});
        end
        @(negedge mclk);
        desc_req = 1'b1;
        @(negedge mclk);
        desc_req = 1'b0;
        chk({7'h00, desc_unsupported}, 8'h01);
    endtask
    task automatic t_pol;
        host.wr(8'h0B, 8'h03);
        chk({7'h00, cfg_rsp.wr_ignored}, 8'h00);
        host.rd(8'h0B, d);
        chk(d, 8'h15);
        host.wr(8'h0B, 8'h83);
        host.rd(8'h0B, d);
        chk(d, 8'h83);
        chk({7'h00, polarity_override_enable}, 8'h01);
        chk({3'h0, core_dp}, 8'h1C);
        chk({3'h0, core_dm}, 8'h03);
    endtask
    task automatic t_uid;
        host.wr(8'h15, 8'h00);
        chk({7'h00, cfg_rsp.wr_ignored}, 8'h01);
        host.rd(8'h15, d);
        chk(d, 8'h55);
        host.rd(8'h30, d);
        chk(d, 8'h00);
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        host.rd(8'h20, d);
        chk(d, 8'h09);
        chk({3'h0, port_pair_swap}, 8'h15);
    endtask
    initial begin
        repeat (12) @(negedge mclk);
        rst = 1'b0;
        t_reset();
        t_lang();
        t_desc();
        t_pol();
        t_uid();
        close_out();
    end
    initial begin
        #100000;
        num_errors++;
        close_out();
    end
endmodule
`default_nettype wire

// File: tb/hcir_host.sv
// Register host model driving the byte request port
`timescale 1ns/100ps
`default_nettype none
module hcir_host (
    input wire logic mclk,
    output var hcir_pkg::hcir_cfg_req_t cfg_req,
    input wire hcir_pkg::hcir_cfg_rsp_t cfg_rsp
);
    import hcir_pkg::*;
    // ****************************************************************
    // Byte cycles launched and ended on falling edges
    // ****************************************************************
    initial cfg_req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        cfg_req = '{a, 1'b1, 1'b0, d};
        @(negedge mclk);
        cfg_req = '{~a, 1'b0, 1'b0, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        cfg_req = '{a, 1'b0, 1'b1, 8'h00};
        @(negedge mclk);
        d = (cfg_rsp.rvalid === 1'b1) ? cfg_rsp.rdata : 'x;
        cfg_req = '{~a, 1'b0, 1'b0, 8'hFF};
    endtask
endmodule
`default_nettype wire

// File: verilog/hcir_config_regs.sv
// Polarity, unique identifier and language code register slice
`timescale 1ns/100ps
`default_nettype none
module hcir_config_regs #(
    parameter int NUM_PORTS = hcir_pkg::HCIR_NUM_PORTS
) (
    input wire logic mclk,
    input wire logic rst,
    input wire hcir_pkg::hcir_cfg_req_t cfg_req,
    output hcir_pkg::hcir_cfg_rsp_t cfg_rsp,
    input wire logic string_override_enable,
    input wire logic [NUM_PORTS-1:0] otp_pair_swap,
    input wire logic [8*hcir_pkg::HCIR_UID_BYTES-1:0] unique_id,
    input wire logic [7:0] lang_code_high,
    output logic [NUM_PORTS-1:0] port_pair_swap,
    output logic polarity_override_enable,
    output logic [7:0] lang_code_low,
    input wire logic [NUM_PORTS-1:0] line_dp,
    input wire logic [NUM_PORTS-1:0] line_dm,
    output logic [NUM_PORTS-1:0] core_dp,
    output logic [NUM_PORTS-1:0] core_dm,
    input wire logic desc_req,
    input wire logic [7:0] desc_index,
    output hcir_pkg::hcir_desc_byte_t desc_byte,
    output logic desc_busy,
    output logic desc_unsupported
);
    import hcir_pkg::*;

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************
    function automatic logic is_uid(input logic [7:0] a);
        is_uid = (a >= HCIR_OFF_UID_FIRST) && (a <= HCIR_OFF_UID_LAST);
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == HCIR_OFF_POLARITY) || (a == HCIR_OFF_LANG_LOW) || is_uid(a);
    endfunction

    logic wr_pol;
    logic wr_lang;
    logic pol_unlock;
    logic [NUM_PORTS-1:0] swap_stored;
    logic [7:0] pol_view;
    logic [3:0] uid_sel;
    logic [7:0] uid_view;
    logic [7:0] next_rdata;

    assign wr_pol = cfg_req.wr && (cfg_req.addr == HCIR_OFF_POLARITY);
    assign wr_lang = cfg_req.wr && (cfg_req.addr == HCIR_OFF_LANG_LOW);
    // Flag and swap bits may arrive in one write
    assign pol_unlock = polarity_override_enable || cfg_req.wdata[HCIR_POL_FLAG_BIT];

    // ****************************************************************
    // Polarity control register
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            polarity_override_enable <= HCIR_RST_POLARITY[HCIR_POL_FLAG_BIT];
        end else if (wr_pol) begin
            polarity_override_enable <= cfg_req.wdata[HCIR_POL_FLAG_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            swap_stored <= HCIR_RST_POLARITY[NUM_PORTS-1:0];
        end else if (wr_pol && pol_unlock) begin
            swap_stored <= cfg_req.wdata[NUM_PORTS-1:0];
        end else if (!polarity_override_enable) begin
            // Tracks the one-time-programmable defaults while locked
            swap_stored <= otp_pair_swap;
        end
    end

    always_comb begin
        port_pair_swap = polarity_override_enable ? swap_stored : otp_pair_swap;
    end

    always_comb begin
        pol_view = 8'h00;
        pol_view[NUM_PORTS-1:0] = port_pair_swap;
        pol_view[HCIR_POL_FLAG_BIT] = polarity_override_enable;
    end

    // ****************************************************************
    // Language code low register
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            lang_code_low <= HCIR_RST_LANG_LOW;
        end else if (wr_lang && string_override_enable) begin
            lang_code_low <= cfg_req.wdata;
        end
    end

    // ****************************************************************
    // Unique identifier bytes
    // ****************************************************************
    assign uid_sel = cfg_req.addr[3:0] - HCIR_OFF_UID_FIRST[3:0];

    always_comb begin
        uid_view = unique_id[uid_sel*8 +: 8];
    end

    // ****************************************************************
    // Read path and write refusal
    // ****************************************************************
    always_comb begin
        next_rdata = HCIR_READ_NONE;
        if (cfg_req.addr == HCIR_OFF_POLARITY) begin
            next_rdata = pol_view;
        end else if (cfg_req.addr == HCIR_OFF_LANG_LOW) begin
            next_rdata = lang_code_low;
        end else if (is_uid(cfg_req.addr)) begin
            next_rdata = uid_view;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_rsp.rdata <= HCIR_READ_NONE;
            cfg_rsp.rvalid <= 1'b0;
        end else begin
            cfg_rsp.rvalid <= cfg_req.rd;
            if (cfg_req.rd) begin
                cfg_rsp.rdata <= next_rdata;
            end
        end
    end

    // Pulses for writes to language low while locked, to read-only or to unmapped offsets; polarity writes never pulse
    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_rsp.wr_ignored <= 1'b0;
        end else begin
            cfg_rsp.wr_ignored <= cfg_req.wr && ((wr_lang && !string_override_enable)
                || is_uid(cfg_req.addr) || !is_mapped(cfg_req.addr));
        end
    end

    // ****************************************************************
    // Line swap and language descriptor
    // ****************************************************************
    hcir_pair_swap #(
        .NUM_PORTS(NUM_PORTS)
    ) u_swap (
        .mclk(mclk),
        .rst(rst),
        .port_pair_swap(port_pair_swap),
        .line_dp(line_dp),
        .line_dm(line_dm),
        .core_dp(core_dp),
        .core_dm(core_dm)
    );

    hcir_lang_desc u_desc (
        .mclk(mclk),
        .rst(rst),
        .desc_req(desc_req),
        .desc_index(desc_index),
        .lang_code_low(lang_code_low),
        .lang_code_high(lang_code_high),
        .desc_byte(desc_byte),
        .desc_busy(desc_busy),
        .desc_unsupported(desc_unsupported)
    );

endmodule
`default_nettype wire

// File: verilog/hcir_lang_desc.sv
// Index 0 string descriptor byte streamer
`timescale 1ns/100ps
`default_nettype none
module hcir_lang_desc (
    input wire logic mclk,
    input wire logic rst,
    input wire logic desc_req,
    input wire logic [7:0] desc_index,
    input wire logic [7:0] lang_code_low,
    input wire logic [7:0] lang_code_high,
    output hcir_pkg::hcir_desc_byte_t desc_byte,
    output logic desc_busy,
    output logic desc_unsupported
);
    import hcir_pkg::*;

    hcir_desc_state_t state;
    logic [1:0] pos;
    logic [7:0] code_low;
    logic [7:0] code_high;

    // Byte at a given position of the four-byte descriptor
    function automatic logic [7:0] desc_at(input logic [1:0] p, input logic [7:0] lo, input logic [7:0] hi);
        case (p)
            2'h0: desc_at = HCIR_DESC_LENGTH;
            2'h1: desc_at = HCIR_DESC_TYPE_STRING;
            2'h2: desc_at = lo;
            default: desc_at = hi;
        endcase
    endfunction

    assign desc_busy = (state == HCIR_DESC_SEND);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= HCIR_DESC_IDLE;
            pos <= 2'h0;
        end else begin
            case (state)
                HCIR_DESC_IDLE: begin
                    if (desc_req && desc_index == HCIR_LANG_DESC_INDEX) begin
                        state <= HCIR_DESC_SEND;
                        pos <= 2'h0;
                    end
                end
                HCIR_DESC_SEND: begin
                    // Stops after one code so only one language is listed
                    if (pos == HCIR_DESC_LAST_POS) begin
                        state <= HCIR_DESC_IDLE;
                    end
                    pos <= pos + 2'h1;
                end
                default: begin
                    state <= HCIR_DESC_IDLE;
                end
            endcase
        end
    end

    // Code is frozen per request so a register write mid-stream cannot tear it
    always_ff @(posedge mclk) begin
        if (rst) begin
            code_low <= HCIR_RST_LANG_LOW;
            code_high <= 8'h00;
        end else if (state == HCIR_DESC_IDLE && desc_req) begin
            code_low <= lang_code_low;
            code_high <= lang_code_high;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            desc_byte <= '0;
        end else if (state == HCIR_DESC_SEND) begin
            desc_byte.data <= desc_at(pos, code_low, code_high);
            desc_byte.valid <= 1'b1;
            desc_byte.last <= (pos == HCIR_DESC_LAST_POS);
        end else begin
            desc_byte <= '0;
        end
    end

    // Other string indices belong to other logic
    always_ff @(posedge mclk) begin
        if (rst) begin
            desc_unsupported <= 1'b0;
        end else begin
            desc_unsupported <= desc_req && (state == HCIR_DESC_IDLE) && (desc_index != HCIR_LANG_DESC_INDEX);
        end
    end

endmodule
`default_nettype wire

// File: verilog/hcir_pair_swap.sv
// Per-port D+/D- line swap between transceiver and core
`timescale 1ns/100ps
`default_nettype none
module hcir_pair_swap #(
    parameter int NUM_PORTS = 5
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [NUM_PORTS-1:0] port_pair_swap,
    input wire logic [NUM_PORTS-1:0] line_dp,
    input wire logic [NUM_PORTS-1:0] line_dm,
    output logic [NUM_PORTS-1:0] core_dp,
    output logic [NUM_PORTS-1:0] core_dm
);
    import hcir_pkg::*;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_port
            always_ff @(posedge mclk) begin
                if (rst) begin
                    core_dp[gi] <= 1'b0;
                    core_dm[gi] <= 1'b0;
                end else if (port_pair_swap[gi]) begin
                    core_dp[gi] <= line_dm[gi];
                    core_dm[gi] <= line_dp[gi];
                end else begin
                    core_dp[gi] <= line_dp[gi];
                    core_dm[gi] <= line_dm[gi];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire
